// [rtl/td_decode_pkg.sv]
// Constants for the transfer descriptor decoder: field positions, limits.
// Assumes descriptor quadwords arrive as {odd dword, even dword} pairs.
//
// Notes on behaviour
// RQ1: The two-bit multiplier gives packets per execution; 01 is usual, 10 and 11 allowed, 00 is illegal.
// RQ2: No data packet may exceed the eleven-bit maximum payload size.
// RQ3: The fifteen-bit byte total must lie between one byte and twenty kilobytes.
// RQ4: Software sets the valid bit to arm a descriptor and hardware clears it on completion or fatal error.
// RQ5: With a zero frame field the slot mask alone sets a rate of one, two or four microframes; the code also sets eight microframes for a single mask bit.
// RQ6: With a nonzero frame field exactly one mask bit is set and the field's top bit selects 2 to 32 ms.
// RQ7: The bulk split descriptor is eight dwords and dwords four to seven are ignored; the code reads the slot mask from the low byte of dword four.
// RQ8: Dword three carries the active, halt, babble, error, split, toggle, counter and progress fields.
// RQ9: Dword two carries the reload field and the sixteen-bit internal buffer start address.
// RQ10: The endpoint number takes bits 34 to 32 for its top and bit 31 for its lowest bit.
// RQ11: Token code 00 issues OUT and code 01 issues IN.
// RQ12: The polling rate is two to the power b minus one microframes, milliseconds in frame bits 7 to 3.
// RQ13: The processor address of the buffer is eight times the internal address plus 400h.
// RQ14: A descriptor whose valid bit is clear never starts a transaction.
// RQ15: Reserved bits are ignored on decode and written back unchanged.

package td_decode_pkg;

  // ****************************************************************
  // Quadword 0 layout
  // ****************************************************************
  localparam int VALID_POS      = 0;
  localparam int BYTES_LSB      = 3;
  localparam int BYTES_MSB      = 17;
  localparam int MAXPKT_LSB     = 18;
  localparam int MAXPKT_MSB     = 28;
  localparam int MULT_LSB       = 29;
  localparam int MULT_MSB       = 30;
  localparam int EP_LOW_POS     = 31;
  localparam int EP_HIGH_LSB    = 32;
  localparam int EP_HIGH_MSB    = 34;
  localparam int TOKEN_LSB      = 42;
  localparam int TOKEN_MSB      = 43;

  // ****************************************************************
  // Quadword 1 layout
  // ****************************************************************
  localparam int FRAME_LSB      = 3;
  localparam int FRAME_MSB      = 7;
  localparam int BASE_LSB       = 8;
  localparam int BASE_MSB       = 23;
  localparam int RELOAD_LSB     = 25;
  localparam int RELOAD_MSB     = 28;
  localparam int DONE_LSB       = 32;
  localparam int DONE_MSB       = 46;
  localparam int NAK_LSB        = 51;
  localparam int NAK_MSB        = 54;
  localparam int CERR_LSB       = 55;
  localparam int CERR_MSB       = 56;
  localparam int TOGGLE_POS     = 57;
  localparam int SPLIT_PH_POS   = 59;
  localparam int XERR_POS       = 60;
  localparam int BABBLE_POS     = 61;
  localparam int HALT_POS       = 62;
  localparam int ACTIVE_POS     = 63;

  // Slot mask sits in the low byte of quadword 2.
  localparam int MASK_LSB       = 0;
  localparam int MASK_MSB       = 7;

  // ****************************************************************
  // Limits and encodings
  // ****************************************************************
  localparam logic [1:0]  MULT_UNDEF   = 2'h0;
  localparam logic [1:0]  TOKEN_OUT    = 2'h0;
  localparam logic [1:0]  TOKEN_IN     = 2'h1;
  localparam logic [14:0] BYTES_MIN    = 15'h0001;
  localparam logic [14:0] BYTES_MAX    = 15'h5000;
  localparam logic [19:0] CPU_OFFSET   = 20'h00400;
  localparam int          ADDR_SHIFT   = 3;
  localparam logic [7:0]  MASK_ALL     = 8'hff;
  localparam logic [7:0]  MASK_EVEN    = 8'haa;
  localparam logic [7:0]  MASK_ODD     = 8'h55;
  localparam logic [3:0]  RATE_B_MS1   = 4'h4;
  localparam logic [3:0]  RATE_B_NONE  = 4'h0;

  typedef enum logic {WAIT_SLOT, RUNNING} run_state_type;

endpackage : td_decode_pkg

// [rtl/poll_rate_decode.sv]
// Decodes the polling rate from frame field and microframe slot mask.
// Purely combinational; the caller registers rate_b, folds rate_legal into desc_legal and uses ms_mask unregistered.
`timescale 1ns/100ps
`default_nettype none

module poll_rate_decode
  import td_decode_pkg::*;
(
  input  wire logic [4:0] frame_field,
  input  wire logic [7:0] slot_mask,
  output var  logic [3:0] rate_b,
  output var  logic [4:0] ms_mask,
  output var  logic       rate_legal
);

  function automatic logic [3:0] ones_in(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : ones_in

  logic [3:0] ones;

  always_comb begin
    ones       = ones_in(slot_mask);
    rate_b     = RATE_B_NONE;
    ms_mask    = 5'h00;
    rate_legal = 1'b0;
    if (frame_field == 5'h00) begin
      rate_legal = 1'b1;
      if (slot_mask == MASK_ALL) begin                              // RQ5
        rate_b = 4'h1;
      end else if (slot_mask == MASK_EVEN || slot_mask == MASK_ODD) begin
        rate_b = 4'h2;
      end else if (ones == 4'h2) begin
        rate_b = 4'h3;
      end else if (ones == 4'h1) begin
        rate_b = RATE_B_MS1;
      end else begin
        rate_legal = 1'b0;
      end
    end else begin
      rate_legal = (ones == 4'h1);                                  // RQ6
      for (int i = 0; i < 5; i++) begin
        if (frame_field[i]) begin
          rate_b  = RATE_B_MS1 + 4'(i + 1);                         // RQ12
          ms_mask = 5'((1 << (i + 1)) - 1);
        end
      end
      // A rate is reported only for a legal mask.
      if (!rate_legal) begin
        rate_b = RATE_B_NONE;
      end
    end
  end

endmodule : poll_rate_decode

`default_nettype wire

// [rtl/td_decode.sv]
// Transfer descriptor decoder and per-descriptor scheduler.
// Assumes a same-clock scheduler supplies sof_tick, frame_count and
// packet events; writeback quadwords are stored back by the caller.
`timescale 1ns/100ps
`default_nettype none

module td_decode
  import td_decode_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         desc_load,
  input  wire logic [255:0] desc_in,
  input  wire logic         sof_tick,
  input  wire logic [7:0]   frame_count,
  input  wire logic         pkt_sent,
  input  wire logic [10:0]  pkt_bytes,
  input  wire logic         fatal_err,
  output var  logic         desc_valid,
  output var  logic         desc_legal,
  output var  logic         xfer_start,
  output var  logic         xfer_done,
  output var  logic         xfer_halted,
  output var  logic [1:0]   packets_left,
  output var  logic         token_is_in,
  output var  logic [3:0]   endpoint_index,
  output var  logic [10:0]  max_payload_bytes,
  output var  logic [19:0]  buffer_cpu_addr,
  output var  logic [3:0]   rate_b,
  output var  logic [63:0]  wb_q0,
  output var  logic [63:0]  wb_q1
);

  // ****************************************************************
  // State
  // ****************************************************************
  run_state_type state, next_state;
  logic [63:0] next_wb_q0, next_wb_q1;
  logic [7:0]  slot_mask, next_slot_mask;
  logic        next_desc_legal, next_xfer_start, next_xfer_done;
  logic        next_xfer_halted;
  logic        next_token_is_in;
  logic [1:0]  next_packets_left;
  logic [19:0] next_buffer_cpu_addr;
  logic [3:0]  next_rate_b;
  logic [4:0]  ms_mask;
  logic [3:0]  dec_rate_b;
  logic        rate_legal, slot_due;
  logic [14:0] bytes_to_move, bytes_done_count, done_sum;
  logic [1:0]  mult;

  poll_rate_decode u_rate (
    .frame_field (wb_q1[FRAME_MSB:FRAME_LSB]),
    .slot_mask   (slot_mask),
    .rate_b      (dec_rate_b),
    .ms_mask     (ms_mask),
    .rate_legal  (rate_legal)
  );

  assign desc_valid        = wb_q0[VALID_POS];
  assign endpoint_index    = {wb_q0[EP_HIGH_MSB:EP_HIGH_LSB],
                              wb_q0[EP_LOW_POS]};                     // RQ10
  assign max_payload_bytes = wb_q0[MAXPKT_MSB:MAXPKT_LSB];
  assign bytes_to_move     = wb_q0[BYTES_MSB:BYTES_LSB];
  assign mult              = wb_q0[MULT_MSB:MULT_LSB];
  assign bytes_done_count  = wb_q1[DONE_MSB:DONE_LSB];
  assign done_sum          = bytes_done_count + {4'h0, pkt_bytes};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_state           = state;
    next_wb_q0           = wb_q0;
    next_wb_q1           = wb_q1;
    next_slot_mask       = slot_mask;
    next_packets_left    = packets_left;
    next_buffer_cpu_addr = buffer_cpu_addr;
    next_rate_b          = dec_rate_b;
    next_xfer_start      = 1'b0;
    next_xfer_done       = 1'b0;
    next_xfer_halted     = 1'b0;
    // A descriptor is legal only with a defined multiplier, a byte
    // total in range, a nonzero payload size and a legal rate.
    next_desc_legal = (mult != MULT_UNDEF)                            // RQ1
                    && bytes_to_move >= BYTES_MIN                     // RQ3
                    && bytes_to_move <= BYTES_MAX
                    && max_payload_bytes != 11'h000 && rate_legal;
    slot_due = sof_tick && slot_mask[frame_count[2:0]]
             && ((frame_count[7:3] & ms_mask) == 5'h00);              // RQ5
    if (desc_load) begin
      // Dwords four to seven are not looked at beyond the slot mask.
      next_wb_q0 = desc_in[63:0];                                     // RQ7
      next_wb_q1 = desc_in[127:64];                                   // RQ9
      next_slot_mask = desc_in[128 + MASK_MSB:128 + MASK_LSB];
      next_buffer_cpu_addr = ({4'h0, desc_in[64 + BASE_MSB:64 + BASE_LSB]}
                             << ADDR_SHIFT) + CPU_OFFSET;             // RQ13
      next_packets_left = 2'h0;
      next_state = WAIT_SLOT;
    end else begin
      unique case (state)
        WAIT_SLOT: begin
          if (desc_valid && desc_legal && slot_due) begin             // RQ14
            next_packets_left = mult;                                 // RQ1
            next_xfer_start = 1'b1;
            next_state = RUNNING;
          end
        end
        RUNNING: begin
          if (fatal_err || (pkt_sent && pkt_bytes > max_payload_bytes)) begin
            next_wb_q0[VALID_POS] = 1'b0;                             // RQ4
            next_wb_q1[ACTIVE_POS] = 1'b0;                            // RQ8
            next_wb_q1[HALT_POS] = 1'b1;
            next_wb_q1[BABBLE_POS] = pkt_sent
                                   && pkt_bytes > max_payload_bytes;  // RQ2
            next_xfer_halted = 1'b1;
            next_packets_left = 2'h0;
            next_state = WAIT_SLOT;
          end else if (pkt_sent) begin
            // The progress field changes, and valid and active clear on completion; reserved bits stay.
            next_wb_q1[DONE_MSB:DONE_LSB] = done_sum;                 // RQ15
            next_packets_left = packets_left - 2'h1;
            if (done_sum >= bytes_to_move) begin
              next_wb_q0[VALID_POS] = 1'b0;                           // RQ4
              next_wb_q1[ACTIVE_POS] = 1'b0;
              next_xfer_done = 1'b1;
              next_packets_left = 2'h0;
              next_state = WAIT_SLOT;
            end else if (packets_left == 2'h1) begin
              next_state = WAIT_SLOT;
            end
          end
        end
      endcase
    end
    next_token_is_in = (next_wb_q0[TOKEN_MSB:TOKEN_LSB] == TOKEN_IN); // RQ11
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state           <= WAIT_SLOT;
      wb_q0           <= 64'h0;
      wb_q1           <= 64'h0;
      slot_mask       <= 8'h00;
      desc_legal      <= 1'b0;
      xfer_start      <= 1'b0;
      xfer_done       <= 1'b0;
      xfer_halted     <= 1'b0;
      packets_left    <= 2'h0;
      buffer_cpu_addr <= 20'h00000;
      rate_b          <= RATE_B_NONE;
      token_is_in     <= 1'b0;
    end else begin
      state           <= next_state;
      wb_q0           <= next_wb_q0;
      wb_q1           <= next_wb_q1;
      slot_mask       <= next_slot_mask;
      desc_legal      <= next_desc_legal;
      xfer_start      <= next_xfer_start;
      xfer_done       <= next_xfer_done;
      xfer_halted     <= next_xfer_halted;
      packets_left    <= next_packets_left;
      buffer_cpu_addr <= next_buffer_cpu_addr;
      rate_b          <= next_rate_b;
      token_is_in     <= next_token_is_in;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_start_needs_valid: assert property ( // RQ14
    @(posedge clk) disable iff (!rst_n)
    xfer_start |-> $past(desc_valid) && $past(desc_legal))
    else $error("Start without a valid legal descriptor.");
  a_mult_nonzero: assert property ( // RQ1
    @(posedge clk) disable iff (!rst_n)
    xfer_start |-> packets_left != MULT_UNDEF)
    else $error("Burst started with undefined multiplier.");
  a_done_clears: assert property ( // RQ4
    @(posedge clk) disable iff (!rst_n)
    xfer_done |-> !desc_valid && !wb_q1[ACTIVE_POS])
    else $error("Completion left the descriptor armed.");
  a_oversize_halts: assert property ( // RQ2
    @(posedge clk) disable iff (!rst_n)
    state == RUNNING && !desc_load && pkt_sent
    && pkt_bytes > max_payload_bytes |=> xfer_halted && wb_q1[BABBLE_POS])
    else $error("Oversize packet not halted.");
  a_legal_range: assert property ( // RQ3
    @(posedge clk) disable iff (!rst_n)
    ##1 desc_legal |-> $past(bytes_to_move) >= BYTES_MIN
    && $past(bytes_to_move) <= BYTES_MAX)
    else $error("Byte total out of range judged legal.");
  a_cpu_addr: assert property ( // RQ13
    @(posedge clk) disable iff (!rst_n)
    desc_load |=> buffer_cpu_addr
    == ({4'h0, wb_q1[BASE_MSB:BASE_LSB]} << ADDR_SHIFT) + CPU_OFFSET)
    else $error("Processor address translation wrong.");
  a_due_mask: assert property ( // RQ5
    @(posedge clk) disable iff (!rst_n)
    xfer_start |-> $past(slot_mask[frame_count[2:0]])
    && $past(sof_tick))
    else $error("Start outside a selected microframe.");
  a_ms_period: assert property ( // RQ6
    @(posedge clk) disable iff (!rst_n)
    xfer_start |-> ($past(frame_count[7:3]) & $past(ms_mask)) == 5'h00)
    else $error("Start outside the millisecond period.");
  a_reserved_kept: assert property ( // RQ15
    @(posedge clk) disable iff (!rst_n)
    !desc_load ##1 1'b1 |-> wb_q0[2:1] == $past(wb_q0[2:1])
    && wb_q1[31:29] == $past(wb_q1[31:29]))
    else $error("Reserved descriptor bits changed.");
  a_burst_ends: assert property ( // RQ1
    @(posedge clk) disable iff (!rst_n)
    state == RUNNING && !desc_load && pkt_sent && packets_left == 2'h1
    |=> state == WAIT_SLOT)
    else $error("Burst ran past its multiplier.");

endmodule : td_decode

`default_nettype wire

// [verif/usb_far_model.sv]
// Far side model: microframe starts and device packet replies.
// Assumes the bench drives its controls just after the rising clock edge.
`timescale 1ns/100ps
`default_nettype none

module usb_far_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sof_en,
  input  wire logic        inject_fatal,
  input  wire logic [3:0]  delay,
  input  wire logic [10:0] pkt_len,
  input  wire logic        xfer_start,
  input  wire logic [1:0]  packets_left,
  output logic             sof_tick,
  output logic [7:0]       frame_count,
  output logic             pkt_sent,
  output logic [10:0]      pkt_bytes,
  output logic             fatal_err
);
  // ****************************************************************
  // Ticks every 8 cycles; replies with one packet per owed slot.
  // ****************************************************************
  logic [2:0] gap;
  logic [1:0] owed;
  logic [3:0] hold;
  logic       s;
  logic       f;

  always @(posedge clk) begin
    s = 1'b0;
    f = 1'b0;
    if (!rst_n) begin
      gap <= 3'h0;
      owed <= 2'h0;
      frame_count <= #1 8'h00;
    end else begin
      gap <= gap + 3'h1;
      if (sof_en && gap == 3'h7) frame_count <= #1 frame_count + 8'h01;
      if (xfer_start) begin
        owed <= packets_left;
        hold <= delay;
      end else if (owed != 2'h0 && hold != 4'h0) begin
        hold <= hold - 4'h1;
      end else if (owed != 2'h0) begin
        f = inject_fatal;
        s = !inject_fatal;
        owed <= inject_fatal ? 2'h0 : owed - 2'h1;
      end
    end
    sof_tick <= #1 rst_n && sof_en && gap == 3'h7;
    pkt_sent <= #1 s;
    fatal_err <= #1 f;
    // Length is only meaningful with the pulse; otherwise it keeps moving.
    pkt_bytes <= #1 s ? pkt_len : ~pkt_bytes;
  end
endmodule : usb_far_model

`default_nettype wire

// [verif/host_transfer_descriptor_decode_test.sv]
// Self-checking bench for the transfer descriptor decoder.
// Assumes the far side model supplies ticks and packet events.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module host_transfer_descriptor_decode_test;
  import td_decode_pkg::*;
  // ****************************************************************
  // Stimulus, partner and design
  // ****************************************************************
  localparam logic [23:0] RATES [12] = '{24'h00ff01, 24'h00aa02,
    24'h005502, 24'h008103, 24'h001004, 24'h010105, 24'h030206,
    24'h048007, 24'h0f0408, 24'h1f0809, 24'h000700, 24'h020300};
  logic clk = 1'b0, rst_n = 1'b0, desc_load = 1'b0, sof_en = 1'b0;
  logic inject_fatal = 1'b0, sof_tick, pkt_sent, fatal_err;
  logic xfer_start, xfer_done, xfer_halted, desc_valid, desc_legal;
  logic token_is_in;
  logic [255:0] desc_in = '0;
  logic [3:0] delay = 4'h0, endpoint_index, rate_b;
  logic [10:0] pkt_len = 11'h000, pkt_bytes, max_payload_bytes;
  logic [7:0] frame_count;
  logic [1:0] packets_left;
  logic [19:0] buffer_cpu_addr;
  logic [63:0] wb_q0, wb_q1;
  int n_mismatch = 0, checked = 0;

  always #5 clk = ~clk;

  usb_far_model far_u (.clk(clk), .rst_n(rst_n), .sof_en(sof_en),
    .inject_fatal(inject_fatal), .delay(delay), .pkt_len(pkt_len),
    .xfer_start(xfer_start), .packets_left(packets_left),
    .sof_tick(sof_tick), .frame_count(frame_count), .pkt_sent(pkt_sent),
    .pkt_bytes(pkt_bytes), .fatal_err(fatal_err));

  td_decode dut_u (.clk(clk), .rst_n(rst_n), .desc_load(desc_load),
    .desc_in(desc_in), .sof_tick(sof_tick), .frame_count(frame_count),
    .pkt_sent(pkt_sent), .pkt_bytes(pkt_bytes), .fatal_err(fatal_err),
    .desc_valid(desc_valid), .desc_legal(desc_legal),
    .xfer_start(xfer_start), .xfer_done(xfer_done),
    .xfer_halted(xfer_halted), .packets_left(packets_left),
    .token_is_in(token_is_in), .endpoint_index(endpoint_index),
    .max_payload_bytes(max_payload_bytes),
    .buffer_cpu_addr(buffer_cpu_addr), .rate_b(rate_b), .wb_q0(wb_q0),
    .wb_q1(wb_q1));

  // Upper dwords carry junk beside the slot mask byte so that any other use of them shows up.
  function automatic logic [255:0] mk(input logic v, input logic [14:0] n,
      input logic [10:0] mp, input logic [1:0] mu, input logic [7:0] fm,
      input logic [7:0] sm, input logic [1:0] tk);
    logic [255:0] d;
    d = {96'ha5a5_5a5a_3c3c_c3c3_0f0f_f0f0, 24'hc3c3c3, sm, 128'h0};
    d[VALID_POS] = v;
    d[BYTES_MSB:BYTES_LSB] = n;
    d[MAXPKT_MSB:MAXPKT_LSB] = mp;
    d[MULT_MSB:MULT_LSB] = mu;
    d[EP_HIGH_MSB:EP_LOW_POS] = 4'hb;
    d[TOKEN_MSB:TOKEN_LSB] = tk;
    d[64+BASE_MSB:64+BASE_LSB] = 16'h1234;
    d[64+FRAME_MSB:64+FRAME_LSB] = fm[4:0];
    d[64+RELOAD_MSB:64+RELOAD_LSB] = 4'ha;
    d[64+TOGGLE_POS] = 1'b1;
    d[64+ACTIVE_POS] = v;
    return d;
  endfunction : mk

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic load(input logic [255:0] d);
    sof_en = 1'b0;
    desc_in = d;
    desc_load = 1'b1;
    @(posedge clk);
    #1 desc_load = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : load

  task automatic await(input int w);
    for (int k = 0; k < 300; k++) begin
      @(posedge clk);
      #1;
      if ((w == 0 && xfer_start === 1'b1) || (w == 1 && xfer_done === 1'b1)
          || (w == 2 && xfer_halted === 1'b1)) return;
    end
    n_mismatch++;
    $display("[ERR] event %0d expected 1 seen 0", w);
    conclude();
  endtask : await

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_fields();
    logic [255:0] d;
    for (int t = 0; t < 2; t++) begin
      d = mk(1'b1, 15'd100, 11'd64, 2'h1, 8'h00, 8'hff, 2'(t));
      load(d);
      `CHK("ep", 4'hb, endpoint_index)
      `CHK("maxpkt", 11'd64, max_payload_bytes)
      `CHK("token", 1'(t), token_is_in)
      `CHK("cpu_addr", 20'h095a0, buffer_cpu_addr)
      `CHK("wb_q0", d[63:0], wb_q0)
      `CHK("wb_q1", d[127:64], wb_q1)
      `CHK("valid", 1'b1, desc_valid)
      `CHK("legal", 1'b1, desc_legal)
    end
  endtask : t_fields

  task automatic t_limits();
    logic [17:0] cfg [5] = '{18'h00064, 18'h20001, 18'h35000, 18'h25001,
                             18'h20000};
    logic [2:0] ok [5] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h0};
    for (int i = 0; i < 5; i++) begin
      load(mk(1'b1, cfg[i][14:0], 11'd64, cfg[i][17:16], 8'h00, 8'hff, 2'h0));
      `CHK("legal_lim", ok[i][0], desc_legal)
    end
  endtask : t_limits

  task automatic t_rates();
    for (int i = 0; i < 12; i++) begin
      load(mk(1'b1, 15'd100, 11'd64, 2'h1, RATES[i][23:16], RATES[i][15:8],
              2'h1));
      `CHK("rate_b", RATES[i][3:0], rate_b)
      `CHK("legal_rate", RATES[i][3:0] != 4'h0, desc_legal)
    end
  endtask : t_rates

  task automatic t_idle();
    int starts = 0;
    load(mk(1'b0, 15'd100, 11'd64, 2'h1, 8'h00, 8'hff, 2'h1));
    sof_en = 1'b1;
    repeat (60) begin
      @(posedge clk);
      #1 starts += (xfer_start === 1'b1);
    end
    `CHK("idle_starts", 0, starts)
  endtask : t_idle

  task automatic t_done(input logic [3:0] dl, input logic [7:0] fm,
      input logic [7:0] sm);
    logic [255:0] d;
    d = mk(1'b1, 15'd100, 11'd64, 2'h2, fm, sm, 2'h0);
    load(d);
    delay = dl;
    pkt_len = 11'd50;
    sof_en = 1'b1;
    await(0);
    `CHK("burst", 2'h2, packets_left)
    `CHK("slot_hit", 1'b1, sm[frame_count[2:0]])
    `CHK("ms_phase", 1'b1, fm == 8'h00 || frame_count[4:3] == 2'h0)
    await(1);
    `CHK("valid_done", 1'b0, desc_valid)
    `CHK("wb_q0_done", {d[63:1], 1'b0}, wb_q0)
    `CHK("moved", 15'd100, wb_q1[DONE_MSB:DONE_LSB])
    `CHK("active", 1'b0, wb_q1[ACTIVE_POS])
    `CHK("reload", 4'ha, wb_q1[RELOAD_MSB:RELOAD_LSB])
    `CHK("base", 16'h1234, wb_q1[BASE_MSB:BASE_LSB])
  endtask : t_done

  task automatic t_halt(input logic fat);
    load(mk(1'b1, 15'd100, 11'd16, 2'h1, 8'h00, 8'hff, 2'h1));
    inject_fatal = fat;
    pkt_len = 11'd50;
    sof_en = 1'b1;
    await(2);
    inject_fatal = 1'b0;
    `CHK("valid_halt", 1'b0, desc_valid)
    `CHK("halt_bits", {1'b0, 1'b1, !fat}, wb_q1[63:61])
  endtask : t_halt

  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("reset_valid", 1'b0, desc_valid)
    t_fields();
    t_limits();
    t_rates();
    t_idle();
    t_done(4'h0, 8'h00, 8'hff);
    t_done(4'h6, 8'h02, 8'h01);
    t_halt(1'b0);
    t_halt(1'b1);
    conclude();
  end
endmodule : host_transfer_descriptor_decode_test

`default_nettype wire
